// ### hdl/udcrc_host.sv
// Host-side Ultra DMA data-out burst controller with CRC generation.
// Assumes the device pins DMARQ, DDMARDY and STOP-related levels arrive
// asynchronously; data and strobe pins are driven from this clock.
`timescale 1ns/1ps
`include "udcrc_defs.svh"
module udcrc_host
  import udcrc_pkg::*;
#(
  parameter int unsigned EXCESS_LIMIT = `UDCRC_EXCESS_DEF,
  parameter int unsigned HALF_PERIOD  = 4
)
(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // User side.
  input  wire logic                  ultra_mode,
  input  wire logic [1:0]            ultra_mode_num,
  input  wire logic                  burst_start,
  input  wire logic                  word_valid,
  output logic                       word_ready,
  input  wire logic [`UDCRC_W-1:0]   word_data,
  input  wire logic                  burst_stop,
  output logic                       burst_done,
  input  wire logic                  status_valid,
  input  wire logic [7:0]            error_reg,
  input  wire logic                  is_packet,
  input  wire logic                  check_condition_bit,
  input  wire logic [3:0]            sense_key,
  output logic                       reissue,
  output logic                       slow_down,
  output logic [`UDCRC_W-1:0]        sent_crc,
  // Device pins.
  input  wire logic                  dmarq,
  input  wire logic                  ddmardy_n,
  output logic                       dmack_n,
  output logic                       stop,
  output logic                       hstrobe,
  output logic [`UDCRC_W-1:0]        d_out,
  output logic                       d_oe
);
  //----------------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------------
  logic [1:0] dmarq_sync_r;
  logic [1:0] rdy_sync_r;

  // Two stages; only the second stage is read by logic.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dmarq_sync_r <= 2'h0;
      rdy_sync_r   <= 2'h3;
    end else begin
      dmarq_sync_r <= {dmarq_sync_r[0], dmarq};
      rdy_sync_r   <= {rdy_sync_r[0], ddmardy_n};
    end
  end

  logic dev_req;
  logic dev_rdy;
  assign dev_req = dmarq_sync_r[1];
  assign dev_rdy = !rdy_sync_r[1];

  //----------------------------------------------------------------------
  // Burst sequencer
  //----------------------------------------------------------------------
  udcrc_state_t state_r;
  udcrc_state_t state_nxt;
  logic [`UDCRC_CNT_W-1:0] tmr_r;
  logic                    tmr_zero;
  logic                    send_word;
  logic                    crc_seed;
  logic [`UDCRC_W-1:0]     crc_now;

  assign tmr_zero = (tmr_r == '0);
  // A word goes out on each strobe toggle while the device is ready.
  assign send_word = (state_r == UDCRC_DATA) && tmr_zero && word_valid && dev_rdy
                     && dev_req && !burst_stop;
  assign word_ready = send_word;
  assign crc_seed   = (state_r == UDCRC_IDLE) && burst_start && ultra_mode;

  // Next state; the burst ends by host stop or device dropping DMARQ.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      UDCRC_IDLE: if (crc_seed) state_nxt = UDCRC_DATA;
      UDCRC_DATA: if (burst_stop || !dev_req) state_nxt = UDCRC_TERM;
      UDCRC_TERM: if (tmr_zero) state_nxt = UDCRC_SHOW;
      UDCRC_SHOW: if (tmr_zero) state_nxt = UDCRC_DONE;
      UDCRC_DONE: state_nxt = UDCRC_IDLE;
      default:    state_nxt = UDCRC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) state_r <= UDCRC_IDLE;
    else       state_r <= state_nxt;
  end

  // Spacing timer: strobe half period in data, setup time before DMACK.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr_r <= '0;
    end else if (send_word) begin
      tmr_r <= `UDCRC_CNT_W'(HALF_PERIOD - 1);
    end else if (state_r == UDCRC_DATA && state_nxt == UDCRC_TERM) begin
      tmr_r <= `UDCRC_CNT_W'(`UDCRC_TDVS_CYC);
    end else if (state_r == UDCRC_TERM && tmr_zero) begin
      tmr_r <= `UDCRC_CNT_W'(`UDCRC_TDVS_CYC);
    end else if (!tmr_zero) begin
      tmr_r <= tmr_r - 1'b1;
    end
  end

  //----------------------------------------------------------------------
  // CRC engine
  //----------------------------------------------------------------------
  // The final strobe return in TERM is not a data edge, so no step.
  udcrc_engine u_crc (
    .clk               (clk),
    .rstn              (rstn),
    .seed              (crc_seed),
    .step              (send_word),
    .word              (word_data),
    .current_crc_value (crc_now)
  );

  //----------------------------------------------------------------------
  // Pin drivers
  //----------------------------------------------------------------------
  // Strobe toggles per word, returns high in TERM; data and CRC registered.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hstrobe <= 1'b1;
      stop    <= 1'b0;
      dmack_n <= 1'b1;
      d_out   <= '0;
      d_oe    <= 1'b0;
    end else begin
      if (crc_seed) dmack_n <= 1'b0;
      if (crc_seed) stop <= 1'b0;
      if (crc_seed) d_oe <= 1'b1;
      if (send_word) begin
        d_out   <= word_data;
        hstrobe <= !hstrobe;
      end
      if (state_r == UDCRC_DATA && state_nxt == UDCRC_TERM) stop <= 1'b1;
      if (state_r == UDCRC_TERM) hstrobe <= 1'b1;
      if (state_r == UDCRC_TERM && tmr_zero) d_out <= crc_now;
      if (state_r == UDCRC_SHOW && tmr_zero) dmack_n <= 1'b1;
      if (state_r == UDCRC_DONE) begin
        d_oe <= 1'b0;
        stop <= 1'b0;
      end
    end
  end

  // Copy of the CRC sent, for software or a retry log.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sent_crc <= '0;
    else if (state_r == UDCRC_TERM && tmr_zero) sent_crc <= crc_now;
  end

  assign burst_done = (state_r == UDCRC_DONE);

  //----------------------------------------------------------------------
  // Error follow-up
  //----------------------------------------------------------------------
  logic dma_crc_err;
  logic [`UDCRC_CNT_W-1:0] err_cnt_r;
  assign dma_crc_err = status_valid && ultra_mode && !is_packet
                       && error_reg[`UDCRC_ERR_INTERFACE_CRC_ERROR_BIT] && error_reg[`UDCRC_ERR_ABORTED_COMMAND_BIT];

  // Reissue pulse for a DMA command ended with the interface CRC error.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) reissue <= 1'b0;
    else       reissue <= dma_crc_err;
  end

  // Count CRC failures, packet hardware errors included, to advise slowing.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_cnt_r <= '0;
      slow_down <= 1'b0;
    end else begin
      if (dma_crc_err || (status_valid && is_packet && check_condition_bit
          && (sense_key == `UDCRC_SK_HWERR || sense_key == `UDCRC_SK_ABORT))) begin
        if (err_cnt_r != '1) err_cnt_r <= err_cnt_r + 1'b1;
      end
      slow_down <= ultra_mode && (ultra_mode_num == 2'h1 || ultra_mode_num == 2'h2)
                   && (err_cnt_r >= `UDCRC_CNT_W'(EXCESS_LIMIT));
    end
  end

  //----------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------
  sequence crc_ready_s;
    state_r == UDCRC_TERM && tmr_zero;
  endsequence
  crc_on_bus_a: assert property (@(posedge clk) disable iff (!rstn)
    crc_ready_s |=> d_out == $past(crc_now)) else $error("CRC not on data lines");
  crc_at_ack_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(dmack_n) |-> d_out == sent_crc && d_oe) else $error("DMACK rose off CRC");
  // The strobe return outside the data phase must follow the stop request.
  no_step_term_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(hstrobe) && state_r != UDCRC_DATA |-> stop) else $error("Strobe return early");
  reissue_a: assert property (@(posedge clk) disable iff (!rstn)
    dma_crc_err |=> reissue) else $error("No reissue after CRC error");
  seed_start_a: assert property (@(posedge clk) disable iff (!rstn)
    crc_seed |=> !dmack_n && state_r == UDCRC_DATA) else $error("Burst start bad");
  ultra_only_a: assert property (@(posedge clk) disable iff (!rstn)
    !ultra_mode |=> !reissue) else $error("Reissue outside Ultra");
endmodule : udcrc_host

// ### shared/udcrc_defs.svh
// Constants for the Ultra DMA burst CRC host-side controller.
// Assumes inclusion by bare name from the package and design files.
//
// Behaviour
// - Host and device each keep a sixteen-bit running CRC value.
// - Each burst seeds the CRC with 4ABAh before its first data word.
// - Every data-carrying strobe edge folds the bus word into the CRC.
// - The strobe return after termination acknowledge carries no data, no update.
// - At burst end host drives its final CRC on data lines while negating DMACK.
// - Host reissues a DMA command that ended with the interface CRC error.
// - Host seeing excessive CRC errors in Ultra mode 2 or 1 drops to slower mode.
// - Polynomial x^16+x^12+x^5+1, word-parallel, equal to serial bit 0 first.
// - Feedback k is D[k-1] xor CRC[16-k] xor terms k-4 and k-11 where present.
// - Next CRC bits are the tabulated XORs of feedback terms.
// - Host sends current CRC bit i on data line i.
// - CRC register clocked per word from the burst strobe, parallel update.
`ifndef UDCRC_DEFS_SVH
`define UDCRC_DEFS_SVH
`define UDCRC_W          16
`define UDCRC_SEED       16'h4ABA
`define UDCRC_ERR_INTERFACE_CRC_ERROR_BIT   7
`define UDCRC_ERR_ABORTED_COMMAND_BIT   2
`define UDCRC_SK_ABORT   4'hB
`define UDCRC_SK_HWERR   4'h4
`define UDCRC_ASC_CRC    8'h08
`define UDCRC_ASCQ_CRC   8'h03
`define UDCRC_TDVS_NS    20
`define UDCRC_CLK_NS     5
`define UDCRC_TDVS_CYC   ((`UDCRC_TDVS_NS + `UDCRC_CLK_NS - 1) / `UDCRC_CLK_NS)
`define UDCRC_CNT_W      8
`define UDCRC_EXCESS_DEF 4
`endif

// ### shared/udcrc_pkg.sv
// Types for the Ultra DMA burst CRC host-side controller.
// Assumes the defines header is on the include path.
`include "udcrc_defs.svh"
package udcrc_pkg;
  // Host burst sequencer states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    UDCRC_IDLE  = 3'h0,
    UDCRC_DATA  = 3'h1,
    UDCRC_TERM  = 3'h3,
    UDCRC_SHOW  = 3'h2,
    UDCRC_DONE  = 3'h6
  } udcrc_state_t;
endpackage : udcrc_pkg

// ### hdl/udcrc_engine.sv
// Word-parallel sixteen-bit CRC engine for Ultra DMA bursts.
// Assumes seed and step are strobes from one clock domain, never both at once.
`timescale 1ns/1ps
`include "udcrc_defs.svh"
module udcrc_engine
  import udcrc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  seed,
  input  wire logic                  step,
  input  wire logic [`UDCRC_W-1:0]   word,
  output logic      [`UDCRC_W-1:0]   current_crc_value
);
  //----------------------------------------------------------------------
  // Parallel next-value function
  //----------------------------------------------------------------------
  // Feedback term k uses data bit k-1 and CRC bit 16-k plus earlier terms.
  function automatic logic [15:0] udcrc_next(input logic [15:0] c, input logic [15:0] d);
    logic [16:1] f;
    logic [15:0] n;
    f = '0;
    for (int k = 1; k <= 16; k++) begin
      f[k] = d[k-1] ^ c[16-k];
      if (k > 4) f[k] = f[k] ^ f[k-4];
      if (k > 11) f[k] = f[k] ^ f[k-11];
    end
    for (int i = 0; i <= 4; i++) n[i] = f[16-i];
    for (int i = 5; i <= 11; i++) n[i] = f[16-i] ^ f[21-i];
    for (int i = 12; i <= 15; i++) n[i] = f[16-i] ^ f[21-i] ^ f[28-i];
    return n;
  endfunction : udcrc_next

  //----------------------------------------------------------------------
  // Running register
  //----------------------------------------------------------------------
  // One update per word strobe; serial shifting would need a bit clock.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      current_crc_value <= `UDCRC_SEED;
    end else if (seed) begin
      current_crc_value <= `UDCRC_SEED;
    end else if (step) begin
      current_crc_value <= udcrc_next(current_crc_value, word);
    end
  end

  seed_value_a: assert property (@(posedge clk) disable iff (!rstn)
    seed |=> current_crc_value == `UDCRC_SEED) else $error("CRC not seeded");
  hold_value_a: assert property (@(posedge clk) disable iff (!rstn)
    !seed && !step |=> $stable(current_crc_value)) else $error("CRC moved idle");
endmodule : udcrc_engine

// ### verification/udcrc_dev_model.sv
// Behavioural model of the storage device at the far end of a data-out burst.
// Assumes the host drives all pins from the same clk that samples them here.
`timescale 1ns/1ps
`include "udcrc_defs.svh"
module udcrc_dev_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hstrobe,
  input  wire logic        dmack_n,
  input  wire logic        stop,
  input  wire logic [15:0] d_out,
  output logic             dmarq,
  output logic             ddmardy_n,
  output logic [15:0]      crc_latched,
  output logic             crc_bad
);
  logic [15:0] crc_r;
  logic        strobe_q;
  logic        ack_q;
  logic [15:0] d_q;

  // Serial reference, bit 0 shifted in first, so it is independent of the host's table.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    logic fb;
    for (int i = 0; i < 16; i++) begin
      fb = d[i] ^ c[15];
      c  = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : crc_step

  // Handshake, running CRC and the check at burst end; the miscompare flag is sticky.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dmarq       <= 1'b1;
      ddmardy_n   <= 1'b1;
      crc_r       <= 16'h0000;
      strobe_q    <= 1'b1;
      ack_q       <= 1'b1;
      d_q         <= 16'h0000;
      crc_latched <= 16'h0000;
      crc_bad     <= 1'b0;
    end else begin
      strobe_q  <= hstrobe;
      ack_q     <= dmack_n;
      d_q       <= d_out;
      dmarq     <= dmack_n ? 1'b1 : (stop ? 1'b0 : dmarq);
      ddmardy_n <= dmack_n | stop;
      if (ack_q && !dmack_n) begin
        crc_r <= `UDCRC_SEED;
      end else if (!dmack_n && !stop && hstrobe !== strobe_q) begin
        crc_r <= crc_step(crc_r, d_out);
      end
      if (!ack_q && dmack_n) begin
        crc_latched <= d_q;
        if (d_q !== crc_r) begin
          crc_bad <= 1'b1;
        end
      end
    end
  end
endmodule : udcrc_dev_model

// ### verification/udma_burst_crc_checker_tb.sv
// Self-checking bench for the host-side burst controller and its CRC.
// Assumes the device model file and the shared package are compiled first.
`timescale 1ns/1ps
`include "udcrc_defs.svh"
module udma_burst_crc_checker_tb;
  import udcrc_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, ultra_mode = 1'b1, burst_start = 1'b0, word_valid = 1'b0;
  logic burst_stop = 1'b0, status_valid = 1'b0, is_packet = 1'b0, check_condition_bit = 1'b0;
  logic [1:0]  ultra_mode_num = 2'h2;
  logic [15:0] word_data = 16'h0000, sent_crc, d_out, crc_latched;
  logic [7:0]  error_reg = 8'h00;
  logic [3:0]  sense_key = 4'h0;
  logic word_ready, burst_done, reissue, slow_down, dmarq, ddmardy_n, dmack_n, stop, hstrobe;
  logic d_oe, crc_bad;
  int n_mismatch = 0, num_checks = 0, cyc = 0;

  always #2.5 clk = ~clk;

  udcrc_host #(.EXCESS_LIMIT(4), .HALF_PERIOD(4)) u_dut (
    .clk(clk), .rstn(rstn), .ultra_mode(ultra_mode), .ultra_mode_num(ultra_mode_num),
    .burst_start(burst_start), .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .burst_stop(burst_stop), .burst_done(burst_done),
    .status_valid(status_valid), .error_reg(error_reg), .is_packet(is_packet),
    .check_condition_bit(check_condition_bit), .sense_key(sense_key), .reissue(reissue),
    .slow_down(slow_down), .sent_crc(sent_crc), .dmarq(dmarq), .ddmardy_n(ddmardy_n),
    .dmack_n(dmack_n), .stop(stop), .hstrobe(hstrobe), .d_out(d_out), .d_oe(d_oe));

  udcrc_dev_model u_dev (
    .clk(clk), .rstn(rstn), .hstrobe(hstrobe), .dmack_n(dmack_n), .stop(stop),
    .d_out(d_out), .dmarq(dmarq), .ddmardy_n(ddmardy_n), .crc_latched(crc_latched),
    .crc_bad(crc_bad));

  // --------------------------------------------------------------------
  // Compare and closing tasks.
  // --------------------------------------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : chk1

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // A hang is cut off well after the few hundred cycles the tests need.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // --------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------
  // One burst of n words; the bench folds each word into its own expected CRC.
  task automatic t_burst(input int n, input logic [15:0] w0);
    logic [15:0] exp;
    logic [15:0] w;
    int k;
    exp = `UDCRC_SEED;
    w   = w0;
    @(negedge clk) burst_start = 1'b1;
    @(negedge clk) burst_start = 1'b0;
    for (int i = 0; i < n; i++) begin
      word_valid = 1'b1;
      word_data  = w;
      k = 0;
      while (word_ready !== 1'b1 && k < 200) begin
        @(negedge clk);
        k++;
      end
      @(negedge clk);
      exp = u_dev.crc_step(exp, w);
      w   = ~w ^ {w[14:0], 1'b1};
    end
    word_valid = 1'b0;
    burst_stop = 1'b1;
    k = 0;
    while (burst_done !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk) burst_stop = 1'b0;
    chk16(sent_crc, exp);
    chk16(crc_latched, exp);
    chk1(crc_bad, 1'b0);
  endtask : t_burst

  // One command-end status; reports whether a reissue pulse followed.
  task automatic t_status(input logic [7:0] er, input logic pk, input logic [3:0] sk,
                          input logic exp);
    logic seen;
    seen = 1'b0;
    @(negedge clk);
    status_valid = 1'b1;
    error_reg = er;
    is_packet = pk;
    check_condition_bit = pk;
    sense_key = sk;
    @(negedge clk) status_valid = 1'b0;
    repeat (3) begin
      seen = seen | (reissue === 1'b1);
      @(negedge clk);
    end
    chk1(seen, exp);
  endtask : t_status

  // --------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    chk1(slow_down, 1'b0);
    t_burst(0, 16'h0000);
    t_burst(3, 16'hFFFF);
    t_burst(5, 16'h0000);
    t_burst(1, 16'hA5A5);
    ultra_mode = 1'b0;
    @(negedge clk) burst_start = 1'b1;
    @(negedge clk) burst_start = 1'b0;
    repeat (4) @(negedge clk);
    chk1(dmack_n, 1'b1);
    t_status(8'h84, 1'b0, 4'h0, 1'b0);
    ultra_mode = 1'b1;
    t_status(8'h80, 1'b0, 4'h0, 1'b0);
    t_status(8'h84, 1'b0, 4'h0, 1'b1);
    chk1(slow_down, 1'b0);
    for (int i = 0; i < 4; i++) begin
      t_status(8'h00, 1'b1, i[0] ? `UDCRC_SK_ABORT : `UDCRC_SK_HWERR, 1'b0);
    end
    chk1(slow_down, 1'b1);
    end_sim();
  end
endmodule : udma_burst_crc_checker_tb
